// *** include/irq_ctrl_pkg.sv ***
// Package for the vectored interrupt controller.
// Assumes an AHB-Lite slave with 32-bit data, one register per word.
package irq_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GLOBAL_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIPH_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h08;
  localparam logic [7:0] ADDR_CMPTB_CTRL  = 8'h0c;
  localparam logic [7:0] ADDR_EDGE_SEL    = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;

  localparam logic [7:0] RESET_BYTE       = 8'h00;
  localparam logic [7:0] CMPTB_WMASK      = 8'h77;
  localparam logic [7:0] EDGE_WMASK       = 8'h0f;
  localparam logic [7:0] GLOBAL_WMASK     = 8'h7f;

  // Bit positions in the first (global) control byte
  localparam int GLB_EN_BIT   = 0;
  localparam int FLAG_SHIFT   = 4;

  // ----------------------------------------------------------------
  // Sources, index order is priority order (0 wins)
  // ----------------------------------------------------------------
  localparam int NSRC = 14;
  localparam int SRC_W = 4;
  typedef enum logic [SRC_W-1:0] {
    SRC_EXT0, SRC_EXT1, SRC_CMP0, SRC_CMP1, SRC_MEMWR, SRC_CONV,
    SRC_LOWV, SRC_SERIAL, SRC_TA_A, SRC_TA_P, SRC_TB_A, SRC_TB_P,
    SRC_TICK0, SRC_TICK1
  } src_t;

  localparam int PC_W     = 12;
  localparam int STACK_D  = 8;
  localparam int SP_W     = 4;
  localparam logic [PC_W-1:0] VEC_BASE = 12'h004;
  localparam logic [PC_W-1:0] VEC_STEP = 12'h004;

  // Edge-select codes
  localparam logic [1:0] EDGE_OFF  = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic            valid;
    logic            write;
    logic [7:0]      addr;
  } bus_req_t;

  typedef struct packed {
    logic            take;
    logic [PC_W-1:0] vector;
  } core_cmd_t;

endpackage : irq_ctrl_pkg

// *** hw/irq_edge_detect.sv ***
// Edge detector for one external interrupt pin.
// Assumes the pin input is already synchronised to CLK.
`timescale 1ns/1ps
module irq_edge_detect (
  input  wire logic       CLK,
  input  wire logic       RSTN,
  input  wire logic       pin,
  input  wire logic [1:0] sel,
  output logic            hit
);
  import irq_ctrl_pkg::*;

  logic last;

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      last <= 1'b0;
    end else begin
      last <= pin;
    end
  end

  // RQ22 edge select decode
  always_comb begin
    case (sel)
      EDGE_RISE: hit = pin & ~last;
      EDGE_FALL: hit = ~pin & last;
      EDGE_BOTH: hit = pin ^ last;
      default:   hit = 1'b0;
    endcase
  end

endmodule : irq_edge_detect

// *** hw/irq_ctrl.sv ***
// Vectored interrupt controller with AHB-Lite register slave.
// Assumes the core pulses fetch-side strobes on CLK; event inputs
// from logic are one-cycle pulses, pins and comparator outputs are async.
//
// Function
// RQ1: Peripheral register: flags in bits 7..4, enables in bits 3..0.
// RQ2: Timer register: four match flags high, four enables low, reset 0.
// RQ3: Third register: comparator1, tick1, tick0 flags and enables.
// RQ4: Third register bits 7 and 3 read zero and ignore writes.
// RQ5: Source events set their flag whatever the enables are.
// RQ6: A flag with its enable clear never causes a vector jump.
// RQ7: Global enable clear blocks all interrupts.
// RQ8: Taking an interrupt pushes the next address and loads the vector.
// RQ9: Return from interrupt pops the saved address and resumes.
// RQ10: Every source has a distinct vector address.
// RQ11: Servicing clears the global enable, preventing nesting.
// RQ12: Events still set flags while interrupts are blocked.
// RQ13: Software sets global enable again inside a routine to nest.
// RQ14: A full stack holds off acknowledgement until it pops.
// RQ15: Simultaneous enabled requests are served in fixed priority.
// RQ16: Any flag becoming set wakes the device from sleep or idle. Only hardware events raise WAKE; a flag set by a software write does not.
// RQ17: External flag sets on the edge chosen by its edge select.
// RQ18: External pin needs enable, pin-share select and input direction.
// RQ19: Servicing an external pin clears its flag and global enable.
// RQ20: Comparator flag sets on any change of its output.
// RQ21: Servicing a comparator clears its flag and global enable.
// RQ22: Two-bit edge select: off, rising, falling, both; reset off.
// RQ23: Global enable is bit 0 of the first register with pins, cmp0.
// RQ24: Servicing other sources clears the serviced source's flag.
// RQ25: Priority and vectors are parameters; lower vector wins. Only the vectors are; priority is fixed by source index.
// RQ26: Software writes beat hardware clears; hardware sets beat clears. For the global enable, the servicing clear beats a write.
`timescale 1ns/1ps
module irq_ctrl #(
  parameter logic [irq_ctrl_pkg::PC_W-1:0] VEC_FIRST =
    irq_ctrl_pkg::VEC_BASE,
  parameter logic [irq_ctrl_pkg::PC_W-1:0] VEC_GAP =
    irq_ctrl_pkg::VEC_STEP
) (
  input  wire logic                          CLK,
  input  wire logic                          RSTN,
  // AHB-Lite slave
  input  wire logic                          HSEL,
  input  wire logic [31:0]                   HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic [31:0]                   HWDATA,
  input  wire logic                          HREADY,
  output logic [31:0]                        HRDATA,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  // Event sources
  input  wire logic                          MEM_WRITE_DONE,
  input  wire logic                          CONV_DONE,
  input  wire logic                          LOW_VOLT,
  input  wire logic                          SERIAL_EVENT,
  input  wire logic [3:0]                    TIMER_MATCH,
  input  wire logic [1:0]                    TICK,
  input  wire logic [1:0]                    LINE_CMP_OUT,
  input  wire logic [1:0]                    EXT_PIN,
  input  wire logic [1:0]                    EXT_PIN_SHARE_SEL,
  input  wire logic [1:0]                    EXT_PIN_IS_INPUT,
  // Core side
  input  wire logic [irq_ctrl_pkg::PC_W-1:0] NEXT_PC,
  input  wire logic                          CORE_READY,
  input  wire logic                          RETURN_FROM_IRQ,
  input  wire logic                          LOW_POWER,
  output irq_ctrl_pkg::core_cmd_t            CORE_CMD,
  output logic [irq_ctrl_pkg::PC_W-1:0]      RETURN_PC,
  output logic                               RETURN_VALID,
  output logic                               WAKE
);
  import irq_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [NSRC-1:0]     flag;
  logic [NSRC-1:0]     en;
  logic                global_irq_en;
  logic [1:0]          ext_edge_select_0;
  logic [1:0]          ext_edge_select_1;
  logic [PC_W-1:0]     stack_mem [STACK_D];
  logic [SP_W-1:0]     sp;
  bus_req_t            req;

  logic [1:0]          ext_s1, ext_s2;
  logic [1:0]          cmp_s1, cmp_s2, cmp_last;
  logic [1:0]          ext_hit;
  logic [NSRC-1:0]     hw_set;
  logic [NSRC-1:0]     pending;
  logic [NSRC-1:0]     service_clr;
  logic [NSRC-1:0]     next_flag;
  logic [NSRC-1:0]     next_en;
  logic                take;
  logic                pop;
  logic [SP_W-1:0]     sp_dec;
  logic [SP_W-2:0]     push_idx;
  logic [SRC_W-1:0]    win;
  logic                stack_full;
  logic                wr_en;
  logic [7:0]          wbyte;

  function automatic logic [PC_W-1:0] vec_of(input logic [SRC_W-1:0] s);
    vec_of = VEC_FIRST + PC_W'(s) * VEC_GAP;
  endfunction : vec_of

  function automatic logic [7:0] byte_of(input logic [3:0] f,
                                         input logic [3:0] e);
    byte_of = {f, e};
  endfunction : byte_of

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ext_s1 <= 2'h0;
      ext_s2 <= 2'h0;
      cmp_s1 <= 2'h0;
      cmp_s2 <= 2'h0;
      cmp_last <= 2'h0;
    end else begin
      ext_s1 <= EXT_PIN;
      ext_s2 <= ext_s1;
      cmp_s1 <= LINE_CMP_OUT;
      cmp_s2 <= cmp_s1;
      cmp_last <= cmp_s2;
    end
  end

  irq_edge_detect u_edge0 (
    .CLK  (CLK),
    .RSTN (RSTN),
    .pin  (ext_s2[0]),
    .sel  (ext_edge_select_0),
    .hit  (ext_hit[0])
  );

  irq_edge_detect u_edge1 (
    .CLK  (CLK),
    .RSTN (RSTN),
    .pin  (ext_s2[1]),
    .sel  (ext_edge_select_1),
    .hit  (ext_hit[1])
  );

  // ----------------------------------------------------------------
  // Event collection
  // ----------------------------------------------------------------
  always_comb begin
    hw_set = '0;
    // RQ17 RQ18 pin qualified edge
    hw_set[SRC_EXT0] = ext_hit[0] & EXT_PIN_SHARE_SEL[0]
                       & EXT_PIN_IS_INPUT[0];
    hw_set[SRC_EXT1] = ext_hit[1] & EXT_PIN_SHARE_SEL[1]
                       & EXT_PIN_IS_INPUT[1];
    // RQ20 comparator toggle detect
    hw_set[SRC_CMP0] = cmp_s2[0] ^ cmp_last[0];
    hw_set[SRC_CMP1] = cmp_s2[1] ^ cmp_last[1];
    // RQ5 RQ12 unconditional flag set
    hw_set[SRC_MEMWR]  = MEM_WRITE_DONE;
    hw_set[SRC_CONV]   = CONV_DONE;
    hw_set[SRC_LOWV]   = LOW_VOLT;
    hw_set[SRC_SERIAL] = SERIAL_EVENT;
    hw_set[SRC_TA_A]   = TIMER_MATCH[3];
    hw_set[SRC_TA_P]   = TIMER_MATCH[2];
    hw_set[SRC_TB_A]   = TIMER_MATCH[1];
    hw_set[SRC_TB_P]   = TIMER_MATCH[0];
    hw_set[SRC_TICK0]  = TICK[0];
    hw_set[SRC_TICK1]  = TICK[1];
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  assign stack_full = (sp == SP_W'(STACK_D));
  // Pop and push may meet in one cycle
  assign pop      = RETURN_FROM_IRQ & (sp != '0);
  assign sp_dec   = sp - SP_W'(1);
  assign push_idx = pop ? sp_dec[SP_W-2:0] : sp[SP_W-2:0];
  // RQ6 RQ7 enable gating
  assign pending = flag & en & {NSRC{global_irq_en}};

  // RQ15 RQ25 fixed priority
  always_comb begin
    win = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        win = SRC_W'(i);
      end
    end
  end

  // RQ14 hold off on full stack
  assign take = (|pending) & ~stack_full & CORE_READY & ~CORE_CMD.take;

  always_comb begin
    service_clr = '0;
    // RQ19 RQ21 RQ24 auto clear served flag
    if (take) begin
      service_clr[win] = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      req <= '0;
    end else if (HREADY) begin
      req.valid <= HSEL & (HTRANS == HTRANS_NONSEQ);
      req.write <= HWRITE;
      req.addr  <= HADDR[7:0];
    end
  end

  assign wr_en = req.valid & req.write;
  assign wbyte = HWDATA[7:0];

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end
  end

  // Read data registered at the address phase
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      HRDATA <= '0;
    end else if (HREADY & HSEL & (HTRANS == HTRANS_NONSEQ) & ~HWRITE) begin
      case (HADDR[7:0])
        ADDR_GLOBAL_CTRL: HRDATA <= {24'h0, 1'b0,
          flag[SRC_EXT1], flag[SRC_EXT0], flag[SRC_CMP0],
          en[SRC_EXT1], en[SRC_EXT0], en[SRC_CMP0], global_irq_en};
        // RQ1 peripheral layout
        ADDR_PERIPH_CTRL: HRDATA <= {24'h0, byte_of(
          {flag[SRC_MEMWR], flag[SRC_CONV], flag[SRC_LOWV],
           flag[SRC_SERIAL]},
          {en[SRC_MEMWR], en[SRC_CONV], en[SRC_LOWV], en[SRC_SERIAL]})};
        // RQ2 timer layout
        ADDR_TIMER_CTRL: HRDATA <= {24'h0, byte_of(
          {flag[SRC_TA_A], flag[SRC_TA_P], flag[SRC_TB_A], flag[SRC_TB_P]},
          {en[SRC_TA_A], en[SRC_TA_P], en[SRC_TB_A], en[SRC_TB_P]})};
        // RQ3 RQ4 third register, bits 7 and 3 zero
        ADDR_CMPTB_CTRL: HRDATA <= {24'h0, byte_of(
          {1'b0, flag[SRC_CMP1], flag[SRC_TICK1], flag[SRC_TICK0]},
          {1'b0, en[SRC_CMP1], en[SRC_TICK1], en[SRC_TICK0]})};
        ADDR_EDGE_SEL: HRDATA <= {28'h0, ext_edge_select_1,
                                  ext_edge_select_0};
        ADDR_STATUS: HRDATA <= {16'h0, 3'h0, stack_full, sp,
                                4'h0, win};
        default: HRDATA <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Flags and enables
  // ----------------------------------------------------------------
  always_comb begin
    next_flag = flag & ~service_clr;
    next_en   = en;
    // RQ26 software write beats hardware clear
    if (wr_en) begin
      case (req.addr)
        ADDR_GLOBAL_CTRL: begin
          {next_flag[SRC_EXT1], next_flag[SRC_EXT0], next_flag[SRC_CMP0]} =
            wbyte[6:4];
          {next_en[SRC_EXT1], next_en[SRC_EXT0], next_en[SRC_CMP0]} =
            wbyte[3:1];
        end
        ADDR_PERIPH_CTRL: begin
          {next_flag[SRC_MEMWR], next_flag[SRC_CONV], next_flag[SRC_LOWV],
           next_flag[SRC_SERIAL]} = wbyte[7:4];
          {next_en[SRC_MEMWR], next_en[SRC_CONV], next_en[SRC_LOWV],
           next_en[SRC_SERIAL]} = wbyte[3:0];
        end
        ADDR_TIMER_CTRL: begin
          {next_flag[SRC_TA_A], next_flag[SRC_TA_P], next_flag[SRC_TB_A],
           next_flag[SRC_TB_P]} = wbyte[7:4];
          {next_en[SRC_TA_A], next_en[SRC_TA_P], next_en[SRC_TB_A],
           next_en[SRC_TB_P]} = wbyte[3:0];
        end
        ADDR_CMPTB_CTRL: begin
          // RQ4 masked reserved bits
          {next_flag[SRC_CMP1], next_flag[SRC_TICK1], next_flag[SRC_TICK0]} =
            wbyte[6:4];
          {next_en[SRC_CMP1], next_en[SRC_TICK1], next_en[SRC_TICK0]} =
            wbyte[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      flag <= '0;
      en   <= '0;
    end else begin
      // RQ26 hardware set wins
      flag <= next_flag | hw_set;
      en   <= next_en;
    end
  end

  // RQ22 edge select storage
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ext_edge_select_0 <= EDGE_OFF;
      ext_edge_select_1 <= EDGE_OFF;
    end else if (wr_en && req.addr == ADDR_EDGE_SEL) begin
      ext_edge_select_0 <= wbyte[1:0];
      ext_edge_select_1 <= wbyte[3:2];
    end
  end

  // RQ23 RQ11 global enable
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      global_irq_en <= 1'b0;
    end else if (take) begin
      global_irq_en <= 1'b0;
    end else if (wr_en && req.addr == ADDR_GLOBAL_CTRL) begin
      global_irq_en <= wbyte[GLB_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Stack and core commands
  // ----------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      sp           <= '0;
      CORE_CMD     <= '0;
      RETURN_PC    <= '0;
      RETURN_VALID <= 1'b0;
    end else begin
      CORE_CMD.take <= take;
      RETURN_VALID  <= pop;
      sp            <= sp + SP_W'(take) - SP_W'(pop);
      if (pop) begin
        // RQ9 pop return address
        RETURN_PC <= stack_mem[sp_dec[SP_W-2:0]];
      end
      if (take) begin
        // RQ8 RQ10 push and vector
        stack_mem[push_idx] <= NEXT_PC;
        CORE_CMD.vector <= vec_of(win);
      end
    end
  end

  // RQ16 wake on any flag newly set by a hardware event
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      WAKE <= 1'b0;
    end else begin
      WAKE <= LOW_POWER & (|(hw_set & ~flag));
    end
  end

endmodule : irq_ctrl

// *** sim/irq_ctrl_props.sv ***
// Checker for the controller's core-side ports.
// Assumes binding to irq_ctrl, one clock, sync active-low reset.
`timescale 1ns/1ps
module irq_ctrl_props #(
  parameter logic [irq_ctrl_pkg::PC_W-1:0] VEC_FIRST =
    irq_ctrl_pkg::VEC_BASE,
  parameter logic [irq_ctrl_pkg::PC_W-1:0] VEC_GAP =
    irq_ctrl_pkg::VEC_STEP
) (
  input wire logic                    CLK,
  input wire logic                    RSTN,
  input wire logic                    CORE_READY,
  input wire logic                    RETURN_FROM_IRQ,
  input wire logic                    RETURN_VALID,
  input wire logic                    LOW_POWER,
  input wire logic                    WAKE,
  input wire irq_ctrl_pkg::core_cmd_t CORE_CMD
);
  import irq_ctrl_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic [3:0]      depth;
  logic [PC_W-1:0] voff;
  assign voff = CORE_CMD.vector - VEC_FIRST;
  // Saved addresses not yet returned
  always_ff @(posedge CLK) begin
    if (!RSTN)
      depth <= 4'h0;
    else if (CORE_CMD.take && !RETURN_FROM_IRQ)
      depth <= depth + 4'h1;
    else if (RETURN_FROM_IRQ && !CORE_CMD.take && depth != 4'h0)
      depth <= depth - 4'h1;
  end
  sequence s_take;
    CORE_CMD.take;
  endsequence
  sequence s_quiet;
    !CORE_CMD.take [*2];
  endsequence
  property p_no_nest;
    s_take |=> s_quiet;
  endproperty
  a_no_nest: assert property (p_no_nest)
    else $error("second take right after a take");
  property p_ready;
    s_take |-> $past(CORE_READY);
  endproperty
  a_ready: assert property (p_ready)
    else $error("take while core not ready");
  property p_stack;
    s_take |-> depth < 4'h8;
  endproperty
  a_stack: assert property (p_stack)
    else $error("take with full stack");
  property p_vec;
    s_take |-> (voff % VEC_GAP == 0) && (voff <= VEC_GAP * 13);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector off the table");
  property p_ret;
    RETURN_VALID |-> $past(RETURN_FROM_IRQ);
  endproperty
  a_ret: assert property (p_ret)
    else $error("return without request");
  property p_ret_pulse;
    RETURN_VALID |=> !RETURN_VALID;
  endproperty
  a_ret_pulse: assert property (p_ret_pulse)
    else $error("return valid too long");
  property p_wake;
    WAKE |-> $past(LOW_POWER);
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake while running");
  property p_wake_pulse;
    WAKE |=> !WAKE;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse)
    else $error("wake too long");
endmodule : irq_ctrl_props

// *** sim/core_model.sv ***
// Model of the core fetch side facing the controller.
// Assumes the controller's clock and sync active-low reset.
`timescale 1ns/1ps
module core_model (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire logic                     slow,
  input  wire logic                     ret_req,
  input  wire irq_ctrl_pkg::core_cmd_t  cmd,
  output logic [irq_ctrl_pkg::PC_W-1:0] next_pc,
  output logic                          ready,
  output logic                          ret,
  output logic [irq_ctrl_pkg::PC_W-1:0] last_vec,
  output int unsigned                   n_take
);
  import irq_ctrl_pkg::*;
  // Running core: address moves every cycle
  always_ff @(posedge clk) begin
    if (!rstn)
      next_pc <= '0;
    else
      next_pc <= next_pc + PC_W'(1);
  end
  // Slow core accepts every other cycle
  always_ff @(posedge clk) begin
    if (!rstn)
      ready <= 1'b0;
    else
      ready <= slow ? ~ready : 1'b1;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      n_take <= 0;
      last_vec <= '0;
    end else if (cmd.take === 1'b1) begin
      n_take <= n_take + 1;
      last_vec <= cmd.vector;
    end
  end
  always_ff @(posedge clk) begin
    ret <= rstn && ret_req;
  end
endmodule : core_model

// *** sim/tb_top.sv ***
// Self-checking bench for the interrupt controller.
// Assumes irq_ctrl, its package, core_model and the checker.
`timescale 1ns/1ps
module tb_top;
  import irq_ctrl_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic low_power = 1'b0, slow = 1'b0, ret_req = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = '0, cmp = '0, pin = '0;
  logic [1:0] share = 2'h3, is_in = 2'h3;
  logic [9:0] ev = '0;
  logic hreadyout, hresp, ready, rvld, wake, rfi, got;
  logic [PC_W-1:0] next_pc, ret_pc, last_vec, push_pc;
  core_cmd_t cmd;
  int n_fail = 0, checked = 0, cyc = 0, n_wake = 0;
  int unsigned n_take;
  logic [7:0] rd;
  always #25 clk = ~clk;
  irq_ctrl irq_ctrl_inst (.CLK(clk), .RSTN(rstn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .MEM_WRITE_DONE(ev[9]),
    .CONV_DONE(ev[8]), .LOW_VOLT(ev[7]), .SERIAL_EVENT(ev[6]),
    .TIMER_MATCH(ev[5:2]), .TICK(ev[1:0]), .LINE_CMP_OUT(cmp),
    .EXT_PIN(pin), .EXT_PIN_SHARE_SEL(share), .EXT_PIN_IS_INPUT(is_in),
    .NEXT_PC(next_pc), .CORE_READY(ready), .RETURN_FROM_IRQ(rfi),
    .LOW_POWER(low_power), .CORE_CMD(cmd), .RETURN_PC(ret_pc),
    .RETURN_VALID(rvld), .WAKE(wake));
  core_model core_model_inst (.clk(clk), .rstn(rstn), .slow(slow),
    .ret_req(ret_req), .cmd(cmd), .next_pc(next_pc), .ready(ready),
    .ret(rfi), .last_vec(last_vec), .n_take(n_take));
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus
  task automatic cmp_byte(input logic [7:0] got_v, input logic [7:0] exp);
    checked++;
    if (got_v !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got_v, exp);
    end
  endtask : cmp_byte
  task automatic cmp_pc(input logic [PC_W-1:0] got_v, input int k);
    logic [PC_W-1:0] exp;
    exp = VEC_BASE + PC_W'(k) * VEC_STEP;
    checked++;
    if (got_v !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got_v, exp);
    end
  endtask : cmp_pc
  task automatic cmp_ret(input logic [PC_W-1:0] got_v,
                         input logic [PC_W-1:0] exp);
    checked++;
    if (got_v !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got_v, exp);
    end
  endtask : cmp_ret
  always @(posedge clk) begin
    if (cmd.take === 1'b1)
      push_pc <= next_pc - PC_W'(1);
  end
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    cmp_byte(rd, exp);
  endtask : rd_chk
  task automatic fire(input logic [9:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= '0;
  endtask : fire
  task automatic wait_take(output logic hit);
    int unsigned n0;
    n0 = n_take;
    hit = 1'b0;
    repeat (12) begin
      @(posedge clk);
      if (n_take != n0)
        hit = 1'b1;
    end
  endtask : wait_take
  task automatic do_ret;
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
  endtask : do_ret
  task automatic results;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (wake === 1'b1)
      n_wake++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    int k;
    logic [7:0] v;
    void'($urandom(32'h5fb3f68a));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (k = 0; k <= 24; k += 4)
      if (k != 20) rd_chk(8'(k), 8'h00);
    for (k = 4; k <= 16; k += 4) begin
      v = 8'($urandom);
      bus(1'b1, 8'(k), v);
      rd_chk(8'(k), v & (k == 12 ? CMPTB_WMASK :
                         k == 16 ? EDGE_WMASK : 8'hff));
      bus(1'b1, 8'(k), 8'h00);
    end
    bus(1'b1, ADDR_CMPTB_CTRL, 8'hff);
    rd_chk(ADDR_CMPTB_CTRL, 8'h77);
    bus(1'b1, ADDR_CMPTB_CTRL, 8'h00);
    $display("test registers done");
    bus(1'b1, ADDR_GLOBAL_CTRL, 8'h01);
    fire(10'h3ff);
    wait_take(got);
    cmp_byte({7'h0, got}, 8'h00);
    rd_chk(ADDR_PERIPH_CTRL, 8'hf0);
    rd_chk(ADDR_TIMER_CTRL, 8'hf0);
    rd_chk(ADDR_CMPTB_CTRL, 8'h30);
    bus(1'b1, ADDR_GLOBAL_CTRL, 8'h00);
    bus(1'b1, ADDR_PERIPH_CTRL, 8'hff);
    bus(1'b1, ADDR_TIMER_CTRL, 8'hff);
    bus(1'b1, ADDR_CMPTB_CTRL, 8'h37);
    wait_take(got);
    cmp_byte({7'h0, got}, 8'h00);
    for (k = 4; k < 14; k++) begin
      slow <= k[0];
      bus(1'b1, ADDR_GLOBAL_CTRL, 8'h01);
      wait_take(got);
      cmp_pc(last_vec, k);
      do_ret();
      repeat (2) @(posedge clk);
      cmp_ret(ret_pc, push_pc);
    end
    rd_chk(ADDR_PERIPH_CTRL, 8'h0f);
    rd_chk(ADDR_TIMER_CTRL, 8'h0f);
    rd_chk(ADDR_CMPTB_CTRL, 8'h07);
    rd_chk(ADDR_GLOBAL_CTRL, 8'h00);
    $display("test priority done");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, ADDR_EDGE_SEL, 8'(k));
      bus(1'b1, ADDR_GLOBAL_CTRL, 8'h04);
      pin <= 2'h1;
      repeat (6) @(posedge clk);
      rd_chk(ADDR_GLOBAL_CTRL, k[0] ? 8'h24 : 8'h04);
      bus(1'b1, ADDR_GLOBAL_CTRL, 8'h04);
      pin <= 2'h0;
      repeat (6) @(posedge clk);
      rd_chk(ADDR_GLOBAL_CTRL, k[1] ? 8'h24 : 8'h04);
    end
    bus(1'b1, ADDR_EDGE_SEL, 8'h01);
    bus(1'b1, ADDR_GLOBAL_CTRL, 8'h05);
    pin <= 2'h1;
    wait_take(got);
    cmp_pc(last_vec, 0);
    rd_chk(ADDR_GLOBAL_CTRL, 8'h04);
    do_ret();
    bus(1'b1, ADDR_GLOBAL_CTRL, 8'h01);
    cmp <= 2'h2;
    wait_take(got);
    cmp_pc(last_vec, 3);
    rd_chk(ADDR_CMPTB_CTRL, 8'h07);
    do_ret();
    cmp <= 2'h0;
    repeat (6) @(posedge clk);
    rd_chk(ADDR_CMPTB_CTRL, 8'h47);
    bus(1'b1, ADDR_CMPTB_CTRL, 8'h07);
    bus(1'b1, ADDR_GLOBAL_CTRL, 8'h04);
    for (k = 1; k <= 2; k++) begin
      share <= (k == 1) ? 2'h2 : 2'h3;
      is_in <= (k == 2) ? 2'h2 : 2'h3;
      pin <= 2'h0;
      repeat (6) @(posedge clk);
      pin <= 2'h1;
      repeat (6) @(posedge clk);
      rd_chk(ADDR_GLOBAL_CTRL, 8'h04);
    end
    share <= 2'h3;
    is_in <= 2'h3;
    $display("test pins done");
    for (k = 0; k < 9; k++) begin
      fire(10'h001);
      bus(1'b1, ADDR_GLOBAL_CTRL, 8'h01);
      wait_take(got);
      cmp_byte({7'h0, got}, k < 8 ? 8'h01 : 8'h00);
    end
    do_ret();
    wait_take(got);
    cmp_byte({7'h0, got}, 8'h01);
    cmp_pc(last_vec, 12);
    low_power <= 1'b1;
    k = n_wake;
    fire(10'h100);
    repeat (4) @(posedge clk);
    cmp_byte(8'(n_wake - k), 8'h01);
    low_power <= 1'b0;
    $display("test stack and wake done");
    results();
  end
endmodule : tb_top
bind irq_ctrl irq_ctrl_props #(.VEC_FIRST(VEC_FIRST), .VEC_GAP(VEC_GAP))
  irq_ctrl_props_inst (.CLK(CLK), .RSTN(RSTN), .CORE_READY(CORE_READY),
    .RETURN_FROM_IRQ(RETURN_FROM_IRQ), .RETURN_VALID(RETURN_VALID),
    .LOW_POWER(LOW_POWER), .WAKE(WAKE), .CORE_CMD(CORE_CMD));
